// file: design/aca_defines.vh
`ifndef ACA_DEFINES_VH
`define ACA_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define ACA_OFF_FEATURES 6'h00
`define ACA_OFF_SEC_COUNT 6'h04
`define ACA_OFF_SEC_NUM 6'h08
`define ACA_OFF_CYL_LO 6'h0c
`define ACA_OFF_CYL_HI 6'h10
`define ACA_OFF_DRIVE_HEAD 6'h14
`define ACA_OFF_COMMAND 6'h18
`define ACA_OFF_STATUS 6'h1c
`define ACA_OFF_ALT_STATUS 6'h20
`define ACA_OFF_CONTROL 6'h24
`define ACA_OFF_DECODE 6'h28

// Drive/head register fields
`define ACA_DH_LBA 6
`define ACA_DH_DRV 4
`define ACA_DH_RESET 8'ha0

// Parameter-use mask bit positions, then the drive-select-only and full masks
`define ACA_PM_FR 0
`define ACA_PM_SC 1
`define ACA_PM_SN 2
`define ACA_PM_CY 3
`define ACA_PM_DRV 4
`define ACA_PM_DHF 5
`define ACA_PM_LBA 6
`define ACA_PM_D 7'h10
`define ACA_PM_FULL 7'h6e

// Acceptance classes
`define ACA_CLASS1 2'h1
`define ACA_CLASS2 2'h2
`define ACA_CLASS3 2'h3

// Command handling kinds
`define ACA_K_NONE 3'h0
`define ACA_K_POWER 3'h1
`define ACA_K_MEDIA 3'h2
`define ACA_K_DIN 3'h3
`define ACA_K_DOUT 3'h4

// Power query answers
`define ACA_PWR_STANDBY 8'h00
`define ACA_PWR_IDLE 8'hff

// Timing, as printed, and the clock rate
`define ACA_CLK_MHZ 100
`define ACA_T_BSY_NS 400
`define ACA_T_DRQ2_US 700
`define ACA_T_DRQ3_MS 20
`define ACA_BSY_MAX_CYC (`ACA_T_BSY_NS * `ACA_CLK_MHZ / 1000)
`define ACA_DRQ2_MAX_CYC (`ACA_T_DRQ2_US * `ACA_CLK_MHZ)
`define ACA_DRQ3_MAX_CYC (`ACA_T_DRQ3_MS * 1000 * `ACA_CLK_MHZ)

// AXI responses
`define ACA_RESP_OKAY 2'h0
`define ACA_RESP_SLVERR 2'h2

`endif

// file: design/aca_cmd_accept.v
`include "aca_defines.vh"
`default_nettype none

// Summary of operation
// - Class one sets busy within 400 ns
// - Class two: busy, DRQ by 700 us, busy off
// - Class three: busy, DRQ by 20 ms, busy off
// - Legacy commands and code 00h complete with no data; standby and idle codes move the power state
// - Read and verify commands decode as class one
// - Single writes, DMA, buffer, format are class two
// - Multiple and verified writes are class three
// - Security commands F1h-F6h use drive select only
// - Geometry, block count, features setup parameter use
// - Native max read; max address set with LBA
// - Diagnostic, identify, flush use drive select only
// - Drive-select-only commands ignore the head bits
// - Full drive/head commands use head bits too
// - Power query in standby returns count 00h
// - Power query in idle returns count FFh
// - Pre-erase moves no data, may write-fault
// - Pre-erase count and start address from registers
// - DRQ marks data phase, cleared at transfer end or by next command
// - LBA bit selects CHS or logical block addressing
module aca_cmd_accept #(
    parameter integer DRQ2_MAX_CYC = `ACA_DRQ2_MAX_CYC,
    parameter integer DRQ3_MAX_CYC = `ACA_DRQ3_MAX_CYC
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [5:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [5:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire buf_ready_i,
    input wire xfer_done_i,
    input wire media_done_i,
    input wire media_fault_i,
    output wire busy_o,
    output wire drq_o,
    output wire intrq_o,
    output wire op_start_o,
    output wire [7:0] op_code_o,
    output wire [1:0] op_class_o,
    output wire erase_o,
    output wire lba_mode_o,
    output wire drive_sel_o,
    output wire [27:0] start_addr_o,
    output wire [7:0] xfer_count_o,
    output wire [7:0] feature_o
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DEC = 3'h1;
    localparam [2:0] ST_PREP = 3'h2;
    localparam [2:0] ST_HAND = 3'h3;
    localparam [2:0] ST_XFER = 3'h4;
    localparam [2:0] ST_MEDIA = 3'h5;

    // Decode: {valid, class, kind, parameter mask}
    function [12:0] decode;
        input [7:0] c;
        begin
            casez (c)
                8'he5, 8'h98: decode = {1'b1, `ACA_CLASS1, `ACA_K_POWER, `ACA_PM_D};
                8'hc0: decode = {1'b1, `ACA_CLASS1, `ACA_K_MEDIA, `ACA_PM_FULL};
                8'h90, 8'he7: decode = {1'b1, `ACA_CLASS1, `ACA_K_MEDIA, `ACA_PM_D};
                8'hec, 8'he4: decode = {1'b1, `ACA_CLASS1, `ACA_K_DIN, `ACA_PM_D};
                8'h20, 8'h21, 8'hc4, 8'hc8, 8'h87:
                    decode = {1'b1, `ACA_CLASS1, `ACA_K_DIN, `ACA_PM_FULL};
                8'h40, 8'h41: decode = {1'b1, `ACA_CLASS1, `ACA_K_MEDIA, `ACA_PM_FULL};
                8'h30, 8'h31, 8'h38, 8'hca:
                    decode = {1'b1, `ACA_CLASS2, `ACA_K_DOUT, `ACA_PM_FULL};
                8'h50: decode = {1'b1, `ACA_CLASS2, `ACA_K_DOUT, 7'h6a};
                8'he8: decode = {1'b1, `ACA_CLASS2, `ACA_K_DOUT, `ACA_PM_D};
                8'hc5, 8'hcd, 8'h3c:
                    decode = {1'b1, `ACA_CLASS3, `ACA_K_DOUT, `ACA_PM_FULL};
                8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf8:
                    decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, `ACA_PM_D};
                8'hf9: decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, `ACA_PM_FULL};
                8'h91: decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, 7'h22};
                8'hc6, 8'he3, 8'h97: decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, 7'h12};
                8'hef: decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, 7'h11};
                8'hb0: decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, 7'h1b};
                8'h7?: decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, 7'h6c};
                // Legacy codes are accepted and finish; the standby and idle codes among them move the power state
                8'h00, 8'h03, 8'h1?, 8'he1, 8'h95, 8'he2, 8'h96, 8'he0, 8'h94, 8'he6, 8'h99:
                    decode = {1'b1, `ACA_CLASS1, `ACA_K_NONE, `ACA_PM_D};
                default: decode = 13'h0000; // Unsupported code
            endcase
        end
    endfunction

    // Reset synchroniser; only the second stage is used
    reg rst_s1_q;
    reg rst_n_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Bus slave state
    reg awready_q;
    reg wready_q;
    reg aw_held_q;
    reg w_held_q;
    reg [5:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg w_strb0_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg arready_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // Task file and core state
    reg [7:0] features_reg_q;
    reg [7:0] sector_count_reg_q;
    reg [7:0] sec_num_q;
    reg [7:0] cyl_lo_q;
    reg [7:0] cyl_hi_q;
    reg [7:0] drive_head_reg_q;
    reg [7:0] cmd_q;
    reg [2:0] state_q;
    reg busy_q;
    reg drq_q;
    reg err_q;
    reg dwf_q;
    reg intrq_q;
    reg standby_q;
    reg [31:0] prep_cnt_q;
    reg [31:0] prep_lim_q;
    reg op_start_q;
    reg [7:0] op_code_q;
    reg [1:0] op_class_q;
    reg erase_q;
    reg lba_mode_q;
    reg drive_sel_q;
    reg [27:0] start_addr_q;
    reg [7:0] xfer_count_q;
    reg [7:0] feature_q;

    wire do_wr = aw_held_q && w_held_q && !bvalid_q;
    wire wb = do_wr && w_strb0_q;
    wire ar_hs = s_axi_arvalid_i && arready_q;
    wire [12:0] dec = decode(cmd_q);
    wire [6:0] pm = dec[6:0];
    wire [7:0] status = {busy_q, 1'b1, dwf_q, !busy_q, drq_q, 2'b00, err_q};
    wire wr_mapped = (aw_addr_q[1:0] == 2'b00) && (aw_addr_q <= `ACA_OFF_DECODE);

    // Read data mux; reserved bits above the byte read zero
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr_i)
            `ACA_OFF_FEATURES: rd_mux = {24'h000000, features_reg_q};
            `ACA_OFF_SEC_COUNT: rd_mux = {24'h000000, sector_count_reg_q};
            `ACA_OFF_SEC_NUM: rd_mux = {24'h000000, sec_num_q};
            `ACA_OFF_CYL_LO: rd_mux = {24'h000000, cyl_lo_q};
            `ACA_OFF_CYL_HI: rd_mux = {24'h000000, cyl_hi_q};
            `ACA_OFF_DRIVE_HEAD: rd_mux = {24'h000000, drive_head_reg_q};
            `ACA_OFF_COMMAND: rd_mux = {24'h000000, cmd_q};
            `ACA_OFF_STATUS, `ACA_OFF_ALT_STATUS: rd_mux = {24'h000000, status};
            `ACA_OFF_CONTROL: rd_mux = {31'h00000000, standby_q};
            `ACA_OFF_DECODE: rd_mux = {24'h000000, intrq_q, lba_mode_q, op_class_q, 1'b0, state_q};
            default: begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // AXI4-Lite handshakes: one write and one read in flight at most
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 6'h00;
            w_data_q <= 32'h00000000;
            w_strb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `ACA_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `ACA_RESP_OKAY;
        end else begin
            // Address and data are held separately and taken in either order
            if (s_axi_awvalid_i && awready_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
                awready_q <= 1'b0;
            end else if (!aw_held_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (s_axi_wvalid_i && wready_q) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb0_q <= s_axi_wstrb_i[0];
                wready_q <= 1'b0;
            end else if (!w_held_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (do_wr) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? `ACA_RESP_OKAY : `ACA_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
            // Read data is captured at the address handshake
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? `ACA_RESP_OKAY : `ACA_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready_i) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    // Command acceptance engine and task file
    always @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            features_reg_q <= 8'h00;
            sector_count_reg_q <= 8'h00;
            sec_num_q <= 8'h00;
            cyl_lo_q <= 8'h00;
            cyl_hi_q <= 8'h00;
            drive_head_reg_q <= `ACA_DH_RESET;
            cmd_q <= 8'h00;
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            drq_q <= 1'b0;
            err_q <= 1'b0;
            dwf_q <= 1'b0;
            intrq_q <= 1'b0;
            standby_q <= 1'b0;
            prep_cnt_q <= 32'h00000000;
            prep_lim_q <= 32'h00000000;
            op_start_q <= 1'b0;
            op_code_q <= 8'h00;
            op_class_q <= 2'h0;
            erase_q <= 1'b0;
            lba_mode_q <= 1'b0;
            drive_sel_q <= 1'b0;
            start_addr_q <= 28'h0000000;
            xfer_count_q <= 8'h00;
            feature_q <= 8'h00;
        end else begin
            op_start_q <= 1'b0;
            erase_q <= 1'b0;
            // Reading the primary status drops the interrupt; a later set wins
            if (ar_hs && s_axi_araddr_i == `ACA_OFF_STATUS) begin
                intrq_q <= 1'b0;
            end
            if (wb && aw_addr_q == `ACA_OFF_CONTROL) begin
                standby_q <= w_data_q[0];
            end
            // Task file is locked to the host while busy
            if (wb && !busy_q) begin
                case (aw_addr_q)
                    `ACA_OFF_FEATURES: features_reg_q <= w_data_q[7:0];
                    `ACA_OFF_SEC_COUNT: sector_count_reg_q <= w_data_q[7:0];
                    `ACA_OFF_SEC_NUM: sec_num_q <= w_data_q[7:0];
                    `ACA_OFF_CYL_LO: cyl_lo_q <= w_data_q[7:0];
                    `ACA_OFF_CYL_HI: cyl_hi_q <= w_data_q[7:0];
                    `ACA_OFF_DRIVE_HEAD: drive_head_reg_q <= w_data_q[7:0];
                    `ACA_OFF_COMMAND: begin
                        // Busy rises on the same edge that the code lands in the command register
                        cmd_q <= w_data_q[7:0];
                        busy_q <= 1'b1;
                        drq_q <= 1'b0;
                        err_q <= 1'b0;
                        dwf_q <= 1'b0;
                        intrq_q <= 1'b0;
                        state_q <= ST_DEC;
                    end
                    default: begin
                    end
                endcase
            end
            case (state_q)
                ST_IDLE: begin
                end
                ST_DEC: begin
                    if (!dec[12]) begin
                        err_q <= 1'b1;
                        busy_q <= 1'b0;
                        intrq_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        // Unused parameters except drive select are forced to zero for the back end
                        op_start_q <= 1'b1;
                        op_code_q <= cmd_q;
                        op_class_q <= dec[11:10];
                        drive_sel_q <= drive_head_reg_q[`ACA_DH_DRV];
                        start_addr_q[27:24] <= pm[`ACA_PM_DHF] ? drive_head_reg_q[3:0]
                                                               : 4'h0;
                        lba_mode_q <= pm[`ACA_PM_LBA]
                                      & drive_head_reg_q[`ACA_DH_LBA];
                        start_addr_q[23:8] <= pm[`ACA_PM_CY] ? {cyl_hi_q, cyl_lo_q} : 16'h0000;
                        start_addr_q[7:0] <= pm[`ACA_PM_SN] ? sec_num_q : 8'h00;
                        xfer_count_q <= pm[`ACA_PM_SC] ? sector_count_reg_q : 8'h00;
                        feature_q <= pm[`ACA_PM_FR] ? features_reg_q : 8'h00;
                        prep_cnt_q <= 32'h00000000;
                        prep_lim_q <= (dec[11:10] == `ACA_CLASS3) ? DRQ3_MAX_CYC - 1
                                                                   : DRQ2_MAX_CYC - 1;
                        case (dec[9:7])
                            `ACA_K_POWER: begin
                                sector_count_reg_q <= standby_q ? `ACA_PWR_STANDBY
                                                                : `ACA_PWR_IDLE;
                                busy_q <= 1'b0;
                                intrq_q <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                            `ACA_K_MEDIA: begin
                                erase_q <= (cmd_q == 8'hc0);
                                state_q <= ST_MEDIA;
                            end
                            `ACA_K_DIN, `ACA_K_DOUT: begin
                                state_q <= ST_PREP;
                            end
                            default: begin
                                // Standby and idle commands move the power state
                                if (cmd_q == 8'he0 || cmd_q == 8'h94 || cmd_q == 8'he2 ||
                                    cmd_q == 8'h96 || cmd_q == 8'he6 || cmd_q == 8'h99) begin
                                    standby_q <= 1'b1;
                                end else if (cmd_q == 8'he1 || cmd_q == 8'h95 ||
                                             cmd_q == 8'he3 || cmd_q == 8'h97) begin
                                    standby_q <= 1'b0;
                                end
                                busy_q <= 1'b0;
                                intrq_q <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_PREP: begin
                    // Deadline forces DRQ even if the buffer is slow
                    prep_cnt_q <= prep_cnt_q + 32'h00000001;
                    if (buf_ready_i || prep_cnt_q >= prep_lim_q) begin
                        drq_q <= 1'b1;
                        state_q <= ST_HAND;
                    end
                end
                ST_HAND: begin
                    busy_q <= 1'b0;
                    state_q <= ST_XFER;
                end
                ST_XFER: begin
                    if (xfer_done_i && !(wb && aw_addr_q == `ACA_OFF_COMMAND)) begin
                        drq_q <= 1'b0;
                        intrq_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_MEDIA: begin
                    if (media_done_i) begin
                        dwf_q <= media_fault_i;
                        err_q <= media_fault_i;
                        busy_q <= 1'b0;
                        intrq_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign busy_o = busy_q;
    assign drq_o = drq_q;
    assign intrq_o = intrq_q;
    assign op_start_o = op_start_q;
    assign op_code_o = op_code_q;
    assign op_class_o = op_class_q;
    assign erase_o = erase_q;
    assign lba_mode_o = lba_mode_q;
    assign drive_sel_o = drive_sel_q;
    assign start_addr_o = start_addr_q;
    assign xfer_count_o = xfer_count_q;
    assign feature_o = feature_q;

endmodule // aca_cmd_accept

`default_nettype wire

// file: testbench/aca_cmd_accept_assertions.sv
`default_nettype none
module aca_cmd_accept_chk #(
    parameter integer DRQ2_MAX_CYC = 8,
    parameter integer DRQ3_MAX_CYC = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic xfer_done_i,
    input wire logic busy_o,
    input wire logic drq_o,
    input wire logic intrq_o,
    input wire logic op_start_o,
    input wire logic [7:0] op_code_o,
    input wire logic [1:0] op_class_o,
    input wire logic erase_o,
    input wire logic [27:0] start_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [5:0] aw_q; // Address of the last accepted write
    // Remember the write address, since the response comes later
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) aw_q <= 6'h00;
        else if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
    end
    bsy_on_cmd_a: assert property (
        $rose(s_axi_bvalid_o) && aw_q == 6'h18 && !$past(busy_o) |-> busy_o)
        else $error("busy not set by command");
    drq_hand_a: assert property ($rose(drq_o) |-> busy_o ##1 !busy_o)
        else $error("busy not dropped after data request");
    xfer_end_a: assert property (
        xfer_done_i && drq_o && !busy_o |=> !drq_o && intrq_o)
        else $error("data phase end wrong");
    intr_idle_a: assert property ($rose(intrq_o) |-> !busy_o && !drq_o)
        else $error("interrupt while busy");
    erase_code_a: assert property (erase_o |-> op_start_o && op_code_o == 8'hc0)
        else $error("erase pulse without erase code");
    head_mask_a: assert property (
        op_start_o && op_code_o inside {8'h90, 8'he7, 8'hec, 8'he4, [8'hf1:8'hf6], 8'hf8}
        |-> start_addr_o[27:24] == 4'h0) else $error("head bits not masked");
    cls_one_a: assert property (
        op_start_o && op_code_o inside {8'h20, 8'h21, 8'hc4, 8'hc8, 8'h40, 8'h41}
        |-> op_class_o == 2'h1) else $error("read not class one");
    cls_two_a: assert property (
        op_start_o && op_code_o inside {8'h30, 8'h31, 8'h38, 8'hca, 8'he8, 8'h50}
        |-> op_class_o == 2'h2) else $error("write not class two");
    cls_three_a: assert property (
        op_start_o && op_code_o inside {8'hc5, 8'hcd, 8'h3c}
        |-> op_class_o == 2'h3) else $error("write not class three");
    cover property ($rose(drq_o));
    cover property (erase_o);
    cover property (op_start_o && op_class_o == 2'h3);
endmodule // aca_cmd_accept_chk
`default_nettype wire

// file: testbench/aca_media_model.sv
`default_nettype none
module aca_media_model (
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic drq_i,
    input wire logic op_start_i,
    input wire logic slow_i,
    input wire logic fault_i,
    output logic buf_ready_o,
    output logic xfer_done_o,
    output logic media_done_o,
    output logic media_fault_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'hff; // Cycles since dispatch, saturating
    // Buffer and media answers are timed from each dispatch, transfer end from DRQ with busy low; a single done pulse per command
    always @(posedge clk_i) begin
        cnt_q <= op_start_i ? 8'h00 : cnt_q + {7'h0, cnt_q != 8'hff};
        media_done_o <= cnt_q == 8'h04;
        xfer_done_o <= drq_i && !busy_i && !xfer_done_o;
    end
    // Slow mode holds the buffer back past every deadline
    assign buf_ready_o = busy_i && (cnt_q > (slow_i ? 8'h64 : 8'h02));
    assign media_fault_o = fault_i && media_done_o; // Fault only with done
endmodule // aca_media_model
`default_nettype wire

// file: testbench/aca_cmd_accept_bench.sv
`default_nettype none
module aca_cmd_accept_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer D2 = 8; // Short deadlines keep the run brief
    localparam integer D3 = 16;
    logic clk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, slow, fault;
    logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, buf_ready_i, xfer_done_i, media_done_i;
    logic media_fault_i, busy_o, drq_o, drq_q, intrq_o, op_start_o, erase_o, lba_mode_o;
    logic drive_sel_o;
    logic [5:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, op_class_o, cls;
    logic [7:0] op_code_o, xfer_count_o, feature_o;
    logic [27:0] start_addr_o, addr;
    integer mismatches = 0, n_checks = 0, i, t_op, t_drq;
    logic [9:0] tbl [31] = '{10'h120, 10'h121, 10'h1c4, 10'h1c8, 10'h140, 10'h141, 10'h230,
        10'h231, 10'h238, 10'h2ca, 10'h2e8, 10'h250, 10'h3c5, 10'h3cd, 10'h33c, 10'h100,
        10'h191, 10'h1c6, 10'h1ef, 10'h1f1, 10'h1f2, 10'h1f3, 10'h1f4, 10'h1f5, 10'h1f6,
        10'h1f8, 10'h1f9, 10'h190, 10'h1e7, 10'h1ec, 10'h1e4}; // Class and code
    aca_cmd_accept #(.DRQ2_MAX_CYC(D2), .DRQ3_MAX_CYC(D3)) i_aca_cmd_accept (.clk_i, .rst_n_i,
        .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .buf_ready_i, .xfer_done_i, .media_done_i,
        .media_fault_i, .busy_o, .drq_o, .intrq_o, .op_start_o, .op_code_o, .op_class_o,
        .erase_o, .lba_mode_o, .drive_sel_o, .start_addr_o, .xfer_count_o, .feature_o);
    aca_media_model i_aca_media_model (.clk_i, .busy_i(busy_o), .drq_i(drq_o),
        .op_start_i(op_start_o), .slow_i(slow), .fault_i(fault), .buf_ready_o(buf_ready_i),
        .xfer_done_o(xfer_done_i), .media_done_o(media_done_i), .media_fault_o(media_fault_i));
    // Free-running clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Snapshot of each dispatch and the delay to the data request
    always @(posedge clk_i) begin
        if (op_start_o) begin
            cls <= op_class_o;
            addr <= start_addr_o;
        end else if (s_axi_bvalid_o) cls <= 2'h0;
        t_op <= op_start_o ? 0 : t_op + 1;
        if (drq_o && !drq_q) t_drq <= t_op;
        drq_q <= drq_o;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write and response ready are held high, so each channel closes on its own
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        chk(s_axi_bresp_o, r);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        chk(s_axi_rdata_o, {24'h0, e});
        chk(s_axi_rresp_o, r);
    endtask
    // Command, wait for completion, then status read which also clears the interrupt
    task automatic cmd(input logic [7:0] c, input logic [7:0] st);
        integer n;
        wr(6'h18, c, 2'h0);
        for (n = 0; n < 400 && !intrq_o; n++) @(posedge clk_i);
        rd(6'h1c, st, 2'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard well beyond the expected run
    initial begin
        #300us;
        mismatches++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, slow, fault} = 5'h00;
        {s_axi_bready_i, s_axi_rready_i} = 2'h3;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 44'h0;
        s_axi_wstrb_i = 4'h1;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(6'h14, 8'ha0, 2'h0);
        rd(6'h3c, 8'h00, 2'h2);
        wr(6'h3c, 8'h00, 2'h2);
        wr(6'h14, 8'hf7, 2'h0);
        for (i = 0; i < 31; i++) begin
            cmd(tbl[i][7:0], 8'h50);
            chk(cls, tbl[i][9:8]);
        end
        cmd(8'hec, 8'h50);
        chk({addr[27:24], drive_sel_o}, 5'h01);
        cmd(8'h20, 8'h50);
        chk(addr[27:24], 4'h7);
        wr(6'h00, 8'h03, 2'h0);
        cmd(8'hef, 8'h50);
        chk(feature_o, 8'h03);
        cmd(8'h01, 8'h51);
        chk(cls, 2'h0);
        wr(6'h04, 8'h5a, 2'h0);
        wr(6'h24, 8'h01, 2'h0);
        cmd(8'he5, 8'h50);
        rd(6'h04, 8'h00, 2'h0);
        wr(6'h24, 8'h00, 2'h0);
        cmd(8'h98, 8'h50);
        rd(6'h04, 8'hff, 2'h0);
        {fault, slow} <= 2'h3;
        wr(6'h04, 8'h03, 2'h0);
        wr(6'h08, 8'h11, 2'h0);
        wr(6'h0c, 8'h22, 2'h0);
        wr(6'h10, 8'h33, 2'h0);
        for (i = 0; i < 2; i++) begin
            wr(6'h14, i ? 8'ha5 : 8'he4, 2'h0);
            cmd(8'hc0, 8'h71);
            chk({addr, lba_mode_o}, {i ? 4'h5 : 4'h4, 24'h332211, !i});
            chk(xfer_count_o, 8'h03);
        end
        cmd(8'hc5, 8'h50);
        chk(t_drq >= D3 - 2 && t_drq <= D3 + 2, 1'b1);
        cmd(8'h30, 8'h50);
        chk(t_drq >= D2 - 2 && t_drq <= D2 + 2, 1'b1);
        tally_and_finish;
    end
endmodule // aca_cmd_accept_bench
bind aca_cmd_accept aca_cmd_accept_chk #(.DRQ2_MAX_CYC(DRQ2_MAX_CYC),
    .DRQ3_MAX_CYC(DRQ3_MAX_CYC)) i_aca_cmd_accept_chk (.clk_i, .rst_n_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bvalid_o, .xfer_done_i, .busy_o, .drq_o,
    .intrq_o, .op_start_o, .op_code_o, .op_class_o, .erase_o, .start_addr_o);
`default_nettype wire
